/* verif/fault_indicator_config_load_test.sv */
// Self-checking bench for the fault indicator and configuration loader.
// Assumes the memory model on a pulled-up two-wire bus and a 25 MHz clock.
`timescale 1ns/1ps
`include "fic_defs.svh"
module fault_indicator_config_load_test;
    typedef struct packed {
        logic amp;
        logic f1k;
        logic fmax;
        logic [13:0] res;
        logic exp;
    } fic_row_s;
    // The full period is far longer than the run, so every fault shows its first low phase.
    localparam fic_row_s rows [8] = '{
        '{1'b0, 1'b0, 1'b0, 14'h0064, 1'b1}, '{1'b1, 1'b0, 1'b0, 14'h0064, 1'b0},
        '{1'b0, 1'b1, 1'b0, 14'h0FFF, 1'b0}, '{1'b0, 1'b0, 1'b1, 14'h0FFF, 1'b1},
        '{1'b0, 1'b0, 1'b1, 14'h1000, 1'b0}, '{1'b0, 1'b1, 1'b0, 14'h1000, 1'b1},
        '{1'b1, 1'b1, 1'b1, 14'h0064, 1'b0}, '{1'b0, 1'b0, 1'b0, 14'h3FFF, 1'b1}};
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic amp_low_i = 1'b0;
    logic freq_over_1k_i = 1'b0;
    logic freq_over_max_i = 1'b0;
    logic [13:0] resolution_i = 14'h0000;
    logic ack_en = 1'b1;
    logic scl_oe_o, sda_oe_o, cfg_done_o, fault_b_o, sda_low;
    logic [7:0] first_byte, cfg_data;
    logic [6:0] cfg_addr = 7'h00;
    int n_bytes;
    int n_errors = 0;
    int total_checks = 0;
    wire logic scl_w = !scl_oe_o;
    wire logic sda_w = !(sda_oe_o || sda_low);
    always #20 clk_i = !clk_i;
    fic_top i_dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .amp_low_i(amp_low_i), .freq_over_1k_i(freq_over_1k_i),
        .freq_over_max_i(freq_over_max_i), .resolution_i(resolution_i), .scl_o(), .scl_oe_o(scl_oe_o),
        .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe_o), .cfg_addr_i(cfg_addr), .cfg_data_o(cfg_data),
        .cfg_done_o(cfg_done_o), .fault_b_o(fault_b_o)
    );
    fic_eeprom_model i_mem (
        .scl_i(scl_w), .sda_i(sda_w), .ack_en_i(ack_en), .sda_low_o(sda_low),
        .first_byte_o(first_byte), .n_bytes_o(n_bytes)
    );
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic apply(input fic_row_s r);
        @(posedge clk_i);
        amp_low_i <= r.amp;
        freq_over_1k_i <= r.f1k;
        freq_over_max_i <= r.fmax;
        resolution_i <= r.res;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(negedge clk_i);
    endtask
    initial begin
        do_reset();
        check(fault_b_o, 1'b1, "indicator after reset");
        for (int i = 0; i < 8; i++) begin
            apply(rows[i]);
            check(fault_b_o, rows[i].exp, "indicator level");
        end
        for (int k = 0; k < 10000 && n_bytes < 2; k++) @(posedge clk_i);
        @(negedge clk_i);
        check(n_bytes >= 2, 1'b1, "no acknowledged bytes");
        check(first_byte, 8'(`FIC_DEV_ADDR_W), "device address");
        check(cfg_done_o, 1'b0, "done during load");
        // Byte k of the memory model is 8'hA5 ^ k and must land at address k.
        for (int k = 0; k < 10000 && n_bytes < 4; k++) @(posedge clk_i);
        @(negedge clk_i);
        check(cfg_data, 8'hA5, "first stored byte");
        @(posedge clk_i);
        cfg_addr <= 7'h01;
        for (int k = 0; k < 5000 && n_bytes < 5; k++) @(posedge clk_i);
        @(negedge clk_i);
        check(cfg_data, 8'hA4, "second stored byte");
        ack_en <= 1'b0;
        do_reset();
        for (int k = 0; k < 8000 && fault_b_o !== 1'b0; k++) @(posedge clk_i);
        @(negedge clk_i);
        check(fault_b_o, 1'b0, "no low after refused address");
        repeat (300) @(posedge clk_i);
        @(negedge clk_i);
        check(fault_b_o, 1'b0, "load failure not held");
        check(cfg_done_o, 1'b0, "done after failed load");
        apply(rows[2]);
        check(fault_b_o, 1'b0, "frequency fault over load failure");
        apply(rows[0]);
        check(fault_b_o, 1'b0, "load failure after fault cleared");
        close_out();
    end
endmodule // fault_indicator_config_load_test

/* verif/fic_eeprom_model.sv */
// Behavioural two-wire configuration memory for the loader bench.
// Assumes pull-ups on both lines; stored byte k reads back as 8'hA5 ^ k.
`timescale 1ns/1ps
module fic_eeprom_model (
    // Bus lines and control
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic ack_en_i,
    // Drive and observation
    output logic sda_low_o,
    output logic [7:0] first_byte_o,
    output int n_bytes_o
);
    logic [7:0] shift_r = 8'h00;
    logic [7:0] rd_byte = 8'h00;
    logic drive_r = 1'b0;
    logic rd_mode = 1'b0;
    int bit_n = 0;
    int idx = 0;
    initial begin
        first_byte_o = 8'h00;
        n_bytes_o = 0;
    end
    // A disabled part never pulls the line, even when a reset cut it off in mid-frame.
    assign sda_low_o = drive_r && ack_en_i;
    // A falling data line while the clock is high starts a new frame.
    always @(negedge sda_i) begin
        if (scl_i) begin
            bit_n = 0;
            idx = 0;
            rd_mode = 1'b0;
        end
    end
    always @(posedge scl_i) begin
        if (bit_n < 8) begin
            shift_r = {shift_r[6:0], sda_i};
        end else if (rd_mode && idx > 0 && sda_i) begin
            // A released line in the master's acknowledge slot ends the read.
            rd_mode = 1'b0;
        end
        bit_n = bit_n + 1;
        if (bit_n == 8 && idx == 0) begin
            first_byte_o = shift_r;
            rd_mode = shift_r[0];
        end
    end
    // The line only changes while the clock is low: acknowledge after bit 8, read data before each bit.
    always @(negedge scl_i) begin
        if (bit_n == 9) begin
            bit_n = 0;
            idx = idx + 1;
            n_bytes_o = n_bytes_o + 1;
        end
        if (bit_n == 8) begin
            drive_r = (idx == 0) || !rd_mode;
        end else if (rd_mode && idx > 0 && bit_n < 8) begin
            rd_byte = 8'hA5 ^ 8'(idx - 1);
            drive_r = !rd_byte[7 - bit_n];
        end else begin
            drive_r = 1'b0;
        end
    end
endmodule // fic_eeprom_model

/* verif/fic_top_sva.sv */
// Port checker for the fault indicator and configuration loader.
// Assumes it is bound to fic_top and that the design has one clock domain.
`timescale 1ns/1ps
`include "fic_defs.svh"
module fic_top_sva (
    // Clock, reset and front-end flags
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic amp_low_i,
    input wire logic freq_over_1k_i,
    input wire logic freq_over_max_i,
    input wire logic [13:0] resolution_i,
    // Watched outputs
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic cfg_done_o,
    input wire logic fault_b_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic quiet;
    logic [20:0] low_run_r;
    logic [20:0] low_run_nxt;
    // Quiet means no front-end fault once the resolution picks the frequency flag.
    assign quiet = !amp_low_i && !(resolution_i < `FIC_RES_LIMIT ? freq_over_1k_i : freq_over_max_i);
    always_comb low_run_nxt = fault_b_o ? 21'h0 : low_run_r + 21'h1;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) low_run_r <= 21'h0;
        else low_run_r <= low_run_nxt;
    end
    rst_vals_a: assert property ($rose(rst_b_i) |-> fault_b_o && !cfg_done_o && !scl_oe_o && !sda_oe_o)
        else $error("outputs not at reset values");
    open_drain_a: assert property (!scl_o && !sda_o)
        else $error("bus line driven high");
    fail_holds_a: assert property (quiet [*5] ##0 $fell(fault_b_o) |=> !fault_b_o [*8])
        else $error("load failure low not held");
    fail_no_done_a: assert property (quiet [*5] ##0 !fault_b_o |-> !cfg_done_o)
        else $error("done while indicator low without fault");
    idle_high_a: assert property (quiet [*5] ##0 cfg_done_o |-> fault_b_o)
        else $error("indicator low without fault");
    done_idle_a: assert property ($rose(cfg_done_o) |-> !scl_oe_o && !sda_oe_o)
        else $error("done before bus released");
    early_done_a: assert property ($rose(rst_b_i) |-> !cfg_done_o [*8])
        else $error("done without a load");
    amp_run_a: assert property (cfg_done_o && !fault_b_o |-> low_run_r < 21'(`FIC_AMP_LOW_CYC))
        else $error("low phase too long");
    fail_c: cover property (quiet [*5] ##0 $fell(fault_b_o));
    amp_c: cover property ($rose(amp_low_i));
    ack_c: cover property ($rose(sda_oe_o));
endmodule // fic_top_sva
bind fic_top fic_top_sva i_sva (.*);

/* verilog/fic_cfg_mem.sv */
// Configuration store loaded from the EEPROM at power-up.
// Assumes one writer during load and a single read port for the interpolator.
`timescale 1ns/1ps
module fic_cfg_mem (
    // Clock
    input wire logic clk_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [6:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    // Read port
    input wire logic [6:0] rd_addr_i,
    output logic [7:0] rd_data_o
);
    logic [7:0] mem_r [0:127];

    // No reset: contents are only valid once the loader reports done.
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_r[rd_addr_i];
    end
endmodule // fic_cfg_mem

/* verilog/fic_defs.svh */
// Constants of the fault indicator and configuration loader.
// Assumes a 25 MHz core clock and an I2C-style two-wire EEPROM.
`ifndef FIC_DEFS_SVH
`define FIC_DEFS_SVH
`define FIC_CLK_HZ 25000000
`define FIC_IND_HZ 16
`define FIC_IND_PERIOD (`FIC_CLK_HZ / `FIC_IND_HZ)
`define FIC_AMP_LOW_PCT 75
`define FIC_FRQ_LOW_PCT 50
`define FIC_AMP_LOW_CYC ((`FIC_IND_PERIOD * `FIC_AMP_LOW_PCT) / (100 + `FIC_AMP_LOW_PCT))
`define FIC_FRQ_LOW_CYC ((`FIC_IND_PERIOD * `FIC_FRQ_LOW_PCT) / (100 + `FIC_FRQ_LOW_PCT))
`define FIC_CFG_BYTES 128
`define FIC_SCL_HZ 100000
`define FIC_SCL_QTR (`FIC_CLK_HZ / (4 * `FIC_SCL_HZ))
`define FIC_DEV_ADDR_W 8'hA0
`define FIC_DEV_ADDR_R 8'hA1
`define FIC_RES_LIMIT 14'h1000
`define FIC_FMAX_LOW_HZ 1000
`endif

/* verilog/fic_pkg.sv */
// Types of the fault indicator and configuration loader.
package fic_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_START, ST_BYTE, ST_ACK, ST_RSTART, ST_RBYTE, ST_RACK, ST_STOP, ST_DONE, ST_FAIL
    } fic_state_e;
    typedef enum logic [1:0] {
        FLT_NONE, FLT_FREQ, FLT_AMP, FLT_CFG
    } fic_fault_e;
endpackage

/* verilog/fic_top.sv */
// Fault indicator output and power-up EEPROM configuration loader.
// Assumes a two-wire EEPROM with pull-ups and analog comparators giving amplitude and frequency
// flags from the sensor front end, synchronised here.
// Overview of operation
// - With no fault the active-low indicator is held high.
// - With an amplitude or frequency fault active and no failed load the indicator carries a 16 Hz PWM wave whose duty depends on the fault.
// - A too-low amplitude (below a tenth of supply) gives a low-to-high ratio of 75 percent.
// - An over-frequency input with no amplitude fault gives a low-to-high ratio of 50 percent.
// - A failed configuration load holds the indicator constantly low.
// - Below 4096 counts of resolution the frequency limit used is 1 kHz.
// - At power-up the configuration is read from the EEPROM before normal operation.
// - Only a too-weak amplitude is flagged; a too-strong one is not.
`timescale 1ns/1ps
`include "fic_defs.svh"
module fic_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Front-end flags
    input wire logic amp_low_i,
    input wire logic freq_over_1k_i,
    input wire logic freq_over_max_i,
    input wire logic [13:0] resolution_i,
    // EEPROM two-wire bus
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Configuration read port
    input wire logic [6:0] cfg_addr_i,
    output logic [7:0] cfg_data_o,
    output logic cfg_done_o,
    // Fault indicator
    output logic fault_b_o
);
    logic [1:0] amp_s_r, f1k_s_r, fmx_s_r, sda_s_r;
    logic [23:0] pwm_r, pwm_nxt;
    logic fault_b_r, fault_b_nxt;
    fic_pkg::fic_fault_e flt;
    logic [23:0] low_cyc;

    fic_pkg::fic_state_e st_r, st_nxt;
    logic [7:0] qtr_r, qtr_nxt;
    logic [1:0] ph_r, ph_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic [6:0] addr_r, addr_nxt;
    logic scl_r, scl_nxt, sda_r, sda_nxt;
    logic wr_en;
    logic tick;

    // Pins from outside the clock domain pass two flip-flops before use.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            amp_s_r <= 2'h0;
            f1k_s_r <= 2'h0;
            fmx_s_r <= 2'h0;
            sda_s_r <= 2'h3;
        end else begin
            amp_s_r <= {amp_s_r[0], amp_low_i};
            f1k_s_r <= {f1k_s_r[0], freq_over_1k_i};
            fmx_s_r <= {fmx_s_r[0], freq_over_max_i};
            sda_s_r <= {sda_s_r[0], sda_i};
        end
    end

    // Fault selection and indicator waveform.
    always_comb begin
        flt = fic_pkg::FLT_NONE;
        if (st_r == fic_pkg::ST_FAIL) begin
            flt = fic_pkg::FLT_CFG;
        end else if (amp_s_r[1]) begin
            flt = fic_pkg::FLT_AMP;
        end else if ((resolution_i < `FIC_RES_LIMIT) ? f1k_s_r[1] : fmx_s_r[1]) begin
            flt = fic_pkg::FLT_FREQ;
        end
        case (flt)
            fic_pkg::FLT_AMP: low_cyc = 24'(`FIC_AMP_LOW_CYC);
            fic_pkg::FLT_FREQ: low_cyc = 24'(`FIC_FRQ_LOW_CYC);
            default: low_cyc = 24'h0;
        endcase
        pwm_nxt = (pwm_r == 24'(`FIC_IND_PERIOD - 1)) ? 24'h0 : pwm_r + 24'h1;
        case (flt)
            fic_pkg::FLT_NONE: fault_b_nxt = 1'b1;
            fic_pkg::FLT_CFG: fault_b_nxt = 1'b0;
            default: fault_b_nxt = (pwm_r >= low_cyc);
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pwm_r <= 24'h0;
            fault_b_r <= 1'b1;
        end else begin
            pwm_r <= pwm_nxt;
            fault_b_r <= fault_b_nxt;
        end
    end

    // EEPROM loader: write address 0, repeated start, sequential read of all bytes.
    // Each bus bit takes four quarter phases; a missing acknowledge ends in the fail state.
    assign tick = (qtr_r == 8'(`FIC_SCL_QTR - 1));

    always_comb begin
        st_nxt = st_r;
        qtr_nxt = tick ? 8'h0 : qtr_r + 8'h1;
        ph_nxt = ph_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        idx_nxt = idx_r;
        addr_nxt = addr_r;
        scl_nxt = scl_r;
        sda_nxt = sda_r;
        wr_en = 1'b0;
        if (tick) begin
            ph_nxt = ph_r + 2'h1;
            case (st_r)
                fic_pkg::ST_IDLE: begin
                    st_nxt = fic_pkg::ST_START;
                    ph_nxt = 2'h0;
                end
                fic_pkg::ST_START, fic_pkg::ST_RSTART: begin
                    case (ph_r)
                        2'h0: begin sda_nxt = 1'b1; scl_nxt = 1'b1; end
                        2'h1: sda_nxt = 1'b0;
                        2'h2: scl_nxt = 1'b0;
                        default: begin
                            st_nxt = fic_pkg::ST_BYTE;
                            bit_nxt = 3'h7;
                            sh_nxt = (st_r == fic_pkg::ST_START) ? `FIC_DEV_ADDR_W : `FIC_DEV_ADDR_R;
                        end
                    endcase
                end
                fic_pkg::ST_BYTE, fic_pkg::ST_RBYTE: begin
                    case (ph_r)
                        2'h0: sda_nxt = (st_r == fic_pkg::ST_BYTE) ? sh_r[7] : 1'b1;
                        2'h1: scl_nxt = 1'b1;
                        2'h2: begin
                            if (st_r == fic_pkg::ST_RBYTE) begin
                                sh_nxt = {sh_r[6:0], sda_s_r[1]};
                            end
                        end
                        default: begin
                            scl_nxt = 1'b0;
                            if (st_r == fic_pkg::ST_BYTE) begin
                                sh_nxt = {sh_r[6:0], 1'b0};
                            end
                            bit_nxt = bit_r - 3'h1;
                            if (bit_r == 3'h0) begin
                                st_nxt = (st_r == fic_pkg::ST_BYTE) ? fic_pkg::ST_ACK : fic_pkg::ST_RACK;
                            end
                        end
                    endcase
                end
                fic_pkg::ST_ACK: begin
                    case (ph_r)
                        2'h0: sda_nxt = 1'b1;
                        2'h1: scl_nxt = 1'b1;
                        2'h2: begin
                            if (sda_s_r[1]) begin
                                st_nxt = fic_pkg::ST_FAIL;
                            end
                        end
                        default: begin
                            scl_nxt = 1'b0;
                            idx_nxt = idx_r + 2'h1;
                            bit_nxt = 3'h7;
                            sh_nxt = 8'h00;
                            // The word address follows, then the repeated start, then the data bytes.
                            case (idx_r)
                                2'h0: st_nxt = fic_pkg::ST_BYTE;
                                2'h1: st_nxt = fic_pkg::ST_RSTART;
                                default: st_nxt = fic_pkg::ST_RBYTE;
                            endcase
                            if (idx_r != 2'h0) begin
                                ph_nxt = 2'h0;
                            end
                        end
                    endcase
                end
                fic_pkg::ST_RACK: begin
                    case (ph_r)
                        2'h0: begin
                            sda_nxt = (addr_r == 7'(`FIC_CFG_BYTES - 1));
                            wr_en = 1'b1;
                        end
                        2'h1: scl_nxt = 1'b1;
                        2'h2: ;
                        default: begin
                            scl_nxt = 1'b0;
                            bit_nxt = 3'h7;
                            addr_nxt = addr_r + 7'h1;
                            st_nxt = (addr_r == 7'(`FIC_CFG_BYTES - 1)) ? fic_pkg::ST_STOP : fic_pkg::ST_RBYTE;
                        end
                    endcase
                end
                fic_pkg::ST_STOP: begin
                    case (ph_r)
                        2'h0: sda_nxt = 1'b0;
                        2'h1: scl_nxt = 1'b1;
                        2'h2: sda_nxt = 1'b1;
                        default: st_nxt = fic_pkg::ST_DONE;
                    endcase
                end
                fic_pkg::ST_DONE, fic_pkg::ST_FAIL: begin
                    scl_nxt = 1'b1;
                    sda_nxt = 1'b1;
                end
                default: st_nxt = fic_pkg::ST_FAIL;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= fic_pkg::ST_IDLE;
            qtr_r <= 8'h0;
            ph_r <= 2'h0;
            bit_r <= 3'h7;
            sh_r <= 8'h00;
            idx_r <= 2'h0;
            addr_r <= 7'h0;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            qtr_r <= qtr_nxt;
            ph_r <= ph_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            idx_r <= idx_nxt;
            addr_r <= addr_nxt;
            scl_r <= scl_nxt;
            sda_r <= sda_nxt;
        end
    end

    // Open-drain: drive only a low level, release for high.
    assign scl_o = 1'b0;
    assign scl_oe_o = !scl_r;
    assign sda_o = 1'b0;
    assign sda_oe_o = !sda_r;
    assign cfg_done_o = (st_r == fic_pkg::ST_DONE);
    assign fault_b_o = fault_b_r;

    // The position path lives in the interpolator and reads this store.
    fic_cfg_mem u_mem (
        .clk_i(clk_i),
        .wr_en_i(wr_en),
        .wr_addr_i(addr_r),
        .wr_data_i(sh_r),
        .rd_addr_i(cfg_addr_i),
        .rd_data_o(cfg_data_o)
    );
endmodule // fic_top
